// file: design/pwm_trigger_and_pin_control.sv
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
// Contract
// - trigger output passes once every divide-field-plus-one trigger events
// - after enable, wait start-delay pwm cycles before first trigger
// - trigger control bits eleven to six read as zero
// - a secondary generator never raises a trigger interrupt
// - per-pin polarity bit set drives that pin active-low while the pwm logic owns it; gpio-owned pins ignore it
// - pair mode 00 complementary, 01 redundant, 10 push-pull
// - swap bit exchanges high-side and low-side pin routing
module pwm_trigger_and_pin_control
    import pwm_trig_pkg::*;
#(
    parameter bit IS_SECONDARY = 1'b0,
    parameter int DATA_W = 16
) (
    input wire logic clk, // 125 MHz clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic [REG_ADDR_W-1:0] reg_addr, // register index
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [DATA_W-1:0] reg_rdata, // read data, cycle after strobe
    input wire logic module_enable, // pwm module enabled
    input wire logic pwm_cycle_start, // pulse at each pwm cycle start
    input wire logic trigger_event, // trigger compare event pulse
    input wire pin_pair_t pwm_raw, // duty and dead-time shaped signals
    input wire pin_pair_t gpio_out, // port logic output levels
    input wire pin_pair_t gpio_oe, // port logic output enables
    input wire logic config_write_lock, // device-level write lock bit
    input wire logic unlock_done, // pulse when unlock sequence ran
    output logic adc_trigger, // postscaled trigger pulse
    output logic trigger_irq, // trigger interrupt request pulse
    output logic high_side_output, // high-side pin level
    output logic high_side_output_oe, // high-side pin drive enable
    output logic low_side_output, // low-side pin level
    output logic low_side_output_oe // low-side pin drive enable
);

    if (DATA_W != 16) begin : g_bad_width
        $error("register data width must be 16");
    end

    // ---------------- register state ----------------
    trig_cfg_t trig_cfg_q, trig_cfg_d;
    pin_cfg_t pin_cfg_q, pin_cfg_d;
    logic unlock_q, unlock_d;
    logic reject_q, reject_d;
    logic [DATA_W-1:0] rdata_d;

    logic wr_trg;
    logic wr_pin;
    logic wr_stat;
    logic pin_wr_ok;

    // ---------------- postscaler ----------------
    logic ps_pulse;
    logic ps_running;
    logic [DIV_W-1:0] ps_count;

    // ---------------- pin path ----------------
    logic phase_q, phase_d;
    pin_pair_t mode_sig;
    pin_pair_t routed;
    logic [1:0] pin_level_d;
    logic [1:0] pin_oe_d;
    logic [1:0] pin_level_q;
    logic [1:0] pin_oe_q;
    logic [1:0] routed_v;
    logic [1:0] owner_v;
    logic [1:0] polarity_v;
    logic [1:0] gpio_out_v;
    logic [1:0] gpio_oe_v;

    logic trig_q, trig_d;
    logic irq_q, irq_d;

    // ---------------- write decode ----------------
    always_comb begin
        wr_trg = reg_wr && (reg_addr == TRGCTL_IDX);
        wr_pin = reg_wr && (reg_addr == PINCTL_IDX);
        wr_stat = reg_wr && (reg_addr == STATUS_IDX);
        pin_wr_ok = !config_write_lock || unlock_q;
    end

    always_comb begin
        trig_cfg_d = trig_cfg_q;
        pin_cfg_d = pin_cfg_q;
        unlock_d = unlock_q;
        reject_d = reject_q;
        if (wr_trg) begin
            trig_cfg_d.trigger_divide_sel = reg_wdata[DIV_LSB +: DIV_W];
            trig_cfg_d.trigger_start_delay = reg_wdata[START_LSB +: START_W];
        end
        if (wr_pin) begin
            if (pin_wr_ok) begin
                pin_cfg_d = pin_cfg_t'(reg_wdata);
            end
            unlock_d = 1'b0;
        end
        if (unlock_done) begin
            unlock_d = 1'b1;
        end
        if (wr_stat && reg_wdata[STAT_REJECT_BIT]) begin
            reject_d = 1'b0;
        end
        if (wr_pin && !pin_wr_ok) begin
            reject_d = 1'b1;
        end
    end

    // ---------------- read mux ----------------
    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            case (reg_addr)
                TRGCTL_IDX: begin
                    rdata_d[DIV_LSB +: DIV_W] = trig_cfg_q.trigger_divide_sel;
                    rdata_d[START_LSB +: START_W] = trig_cfg_q.trigger_start_delay;
                end
                PINCTL_IDX: begin
                    rdata_d = DATA_W'(pin_cfg_q);
                end
                STATUS_IDX: begin
                    rdata_d[STAT_UNLOCK_BIT] = unlock_q;
                    rdata_d[STAT_REJECT_BIT] = reject_q;
                    rdata_d[STAT_RUN_BIT] = ps_running;
                    rdata_d[STAT_PHASE_BIT] = phase_q;
                    rdata_d[STAT_CNT_LSB +: DIV_W] = ps_count;
                    rdata_d[STAT_PIN_H_BIT] = pin_level_q[1];
                    rdata_d[STAT_PIN_L_BIT] = pin_level_q[0];
                end
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trig_cfg_q <= trig_cfg_t'({TRGCTL_RST[DIV_LSB +: DIV_W],
                                       TRGCTL_RST[START_LSB +: START_W]});
            pin_cfg_q <= pin_cfg_t'(PINCTL_RST);
            unlock_q <= 1'b0;
            reject_q <= 1'b0;
            reg_rdata <= '0;
        end else begin
            trig_cfg_q <= trig_cfg_d;
            pin_cfg_q <= pin_cfg_d;
            unlock_q <= unlock_d;
            reject_q <= reject_d;
            reg_rdata <= rdata_d;
        end
    end

    // ---------------- trigger path ----------------
    trig_postscaler #(
        .CNT_W(DIV_W),
        .DLY_W(START_W)
    ) u_postscaler (
        .clk(clk),
        .sys_rst(sys_rst),
        .module_enable(module_enable),
        .cycle_start(pwm_cycle_start),
        .trigger_event(trigger_event),
        .cfg(trig_cfg_q),
        .trig_pulse_q(ps_pulse),
        .running_q(ps_running),
        .event_cnt_q(ps_count)
    );

    always_comb begin
        trig_d = ps_pulse;
        irq_d = ps_pulse && !IS_SECONDARY;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trig_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            trig_q <= trig_d;
            irq_q <= irq_d;
        end
    end

    assign adc_trigger = trig_q;
    assign trigger_irq = irq_q;

    // ---------------- pair mode ----------------
    // push-pull alternates the pin that carries the pulse each pwm cycle
    always_comb begin
        phase_d = phase_q;
        if (!module_enable) begin
            phase_d = 1'b0;
        end else if (pwm_cycle_start) begin
            phase_d = !phase_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
        end
    end

    always_comb begin
        case (pin_cfg_q.output_pair_mode)
            PAIR_COMPL: begin
                mode_sig = pwm_raw;
            end
            PAIR_REDUND: begin
                mode_sig.high = pwm_raw.high;
                mode_sig.low = pwm_raw.high;
            end
            PAIR_PUSHPULL: begin
                mode_sig.high = pwm_raw.high && !phase_q;
                mode_sig.low = pwm_raw.high && phase_q;
            end
            default: begin
                mode_sig = pwm_raw;
            end
        endcase
        if (!module_enable) begin
            mode_sig = '0;
        end
    end

    always_comb begin
        if (pin_cfg_q.swap) begin
            routed.high = mode_sig.low;
            routed.low = mode_sig.high;
        end else begin
            routed = mode_sig;
        end
    end

    // ---------------- per-pin output stage, index 1 high, 0 low ----------------
    always_comb begin
        routed_v = {routed.high, routed.low};
        owner_v = {pin_cfg_q.high_pin_owner, pin_cfg_q.low_pin_owner};
        polarity_v = {pin_cfg_q.high_pin_polarity, pin_cfg_q.low_pin_polarity};
        gpio_out_v = {gpio_out.high, gpio_out.low};
        gpio_oe_v = {gpio_oe.high, gpio_oe.low};
    end

    for (genvar i = 0; i < 2; i++) begin : g_pin
        always_comb begin
            if (owner_v[i]) begin
                pin_level_d[i] = routed_v[i] ^ polarity_v[i];
                pin_oe_d[i] = 1'b1;
            end else begin
                pin_level_d[i] = gpio_out_v[i];
                pin_oe_d[i] = gpio_oe_v[i];
            end
        end

        always_ff @(posedge clk) begin
            if (sys_rst) begin
                pin_level_q[i] <= 1'b0;
                pin_oe_q[i] <= 1'b0;
            end else begin
                pin_level_q[i] <= pin_level_d[i];
                pin_oe_q[i] <= pin_oe_d[i];
            end
        end
    end

    assign high_side_output = pin_level_q[1];
    assign high_side_output_oe = pin_oe_q[1];
    assign low_side_output = pin_level_q[0];
    assign low_side_output_oe = pin_oe_q[0];

endmodule : pwm_trigger_and_pin_control

// file: pkg/pwm_trig_pkg.sv
package pwm_trig_pkg;

    // register indices on the plain register port
    localparam int REG_ADDR_W = 2;
    localparam logic [1:0] TRGCTL_IDX = 2'h0;
    localparam logic [1:0] PINCTL_IDX = 2'h1;
    localparam logic [1:0] STATUS_IDX = 2'h2;

    // trigger_postscale_control layout
    localparam int DIV_LSB = 12;
    localparam int DIV_W = 4;
    localparam int START_LSB = 0;
    localparam int START_W = 6;
    localparam logic [15:0] TRGCTL_RST = 16'h0000;

    // output_pin_control after reset: both pins owned by the pwm logic
    localparam logic [15:0] PINCTL_RST = 16'hc000;

    // status register layout
    localparam int STAT_UNLOCK_BIT = 0;
    localparam int STAT_REJECT_BIT = 1;
    localparam int STAT_RUN_BIT = 2;
    localparam int STAT_PHASE_BIT = 3;
    localparam int STAT_CNT_LSB = 4;
    localparam int STAT_PIN_H_BIT = 8;
    localparam int STAT_PIN_L_BIT = 9;

    typedef enum logic [1:0] {
        PAIR_COMPL = 2'h0,
        PAIR_REDUND = 2'h1,
        PAIR_PUSHPULL = 2'h2,
        PAIR_RSVD = 2'h3
    } pair_mode_t;

    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_DELAY = 2'b01,
        PS_RUN = 2'b11
    } postscale_state_t;

    typedef struct packed {
        logic [DIV_W-1:0] trigger_divide_sel;
        logic [START_W-1:0] trigger_start_delay;
    } trig_cfg_t;

    // field order matches the register bits 15 down to 0
    typedef struct packed {
        logic high_pin_owner;
        logic low_pin_owner;
        logic high_pin_polarity;
        logic low_pin_polarity;
        pair_mode_t output_pair_mode;
        logic [1:0] override_en;
        logic [1:0] override_data;
        logic [1:0] fault_data;
        logic [1:0] limit_data;
        logic swap;
        logic override_time_sync;
    } pin_cfg_t;

    typedef struct packed {
        logic high;
        logic low;
    } pin_pair_t;

endpackage : pwm_trig_pkg

// file: design/trig_postscaler.sv
`timescale 1ns/1ps
module trig_postscaler
    import pwm_trig_pkg::*;
#(
    parameter int CNT_W = DIV_W,
    parameter int DLY_W = START_W
) (
    input wire logic clk, // 125 MHz clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic module_enable, // pwm module enabled
    input wire logic cycle_start, // pulse at each pwm cycle start
    input wire logic trigger_event, // pulse per trigger compare event
    input wire trig_cfg_t cfg, // divide and start delay
    output logic trig_pulse_q, // one-cycle trigger output
    output logic running_q, // start delay has elapsed
    output logic [CNT_W-1:0] event_cnt_q // events since last output
);

    if (CNT_W != DIV_W || DLY_W != START_W) begin : g_bad_width
        $error("trig_postscaler widths must match the register fields");
    end

    postscale_state_t state_q, state_d;
    logic [DLY_W-1:0] delay_cnt_q, delay_cnt_d;
    logic [CNT_W-1:0] event_cnt_d;
    logic trig_pulse_d;

    always_comb begin
        state_d = state_q;
        delay_cnt_d = delay_cnt_q;
        event_cnt_d = event_cnt_q;
        trig_pulse_d = 1'b0;
        case (state_q)
            PS_IDLE: begin
                delay_cnt_d = '0;
                event_cnt_d = '0;
                if (module_enable) begin
                    state_d = (cfg.trigger_start_delay == '0) ? PS_RUN : PS_DELAY;
                end
            end
            PS_DELAY: begin
                if (cycle_start) begin
                    delay_cnt_d = delay_cnt_q + 1'b1;
                    if (delay_cnt_d >= cfg.trigger_start_delay) begin
                        state_d = PS_RUN;
                    end
                end
            end
            PS_RUN: begin
                if (trigger_event) begin
                    if (event_cnt_q >= cfg.trigger_divide_sel) begin
                        event_cnt_d = '0;
                        trig_pulse_d = 1'b1;
                    end else begin
                        event_cnt_d = event_cnt_q + 1'b1;
                    end
                end
            end
            default: state_d = PS_IDLE;
        endcase
        if (!module_enable) begin
            state_d = PS_IDLE;
            trig_pulse_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= PS_IDLE;
            delay_cnt_q <= '0;
            event_cnt_q <= '0;
            trig_pulse_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            state_q <= state_d;
            delay_cnt_q <= delay_cnt_d;
            event_cnt_q <= event_cnt_d;
            trig_pulse_q <= trig_pulse_d;
            running_q <= (state_d == PS_RUN);
        end
    end

endmodule : trig_postscaler

// file: verification/pin_ctl_checker.sv
`timescale 1ns/1ps
module pin_ctl_checker
    import pwm_trig_pkg::*;
#(
    parameter bit IS_SECONDARY = 1'b0
) (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic [REG_ADDR_W-1:0] reg_addr, // index
    input wire logic reg_rd, // read strobe
    input wire logic [15:0] reg_rdata, // read data
    input wire logic module_enable, // enable
    input wire logic trigger_event, // event
    input wire logic adc_trigger, // trigger out
    input wire logic trigger_irq, // irq out
    input wire logic high_side_output_oe, // high enable
    input wire logic low_side_output_oe // low enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence rd_trg_s;
        reg_rd && reg_addr == TRGCTL_IDX;
    endsequence
    sequence rd_none_s;
        reg_rd && reg_addr == 2'h3;
    endsequence
    trig_from_event_a: assert property (adc_trigger |-> $past(trigger_event, 2))
        else $error("trigger without event");
    trig_when_enabled_a: assert property (adc_trigger |-> $past(module_enable, 2))
        else $error("trigger while disabled");
    reserved_zero_a: assert property (rd_trg_s |=> reg_rdata[11:6] == 6'h0)
        else $error("reserved bits not zero");
    irq_source_a: assert property (trigger_irq |-> !IS_SECONDARY && adc_trigger)
        else $error("unexpected interrupt");
    irq_follows_a: assert property (adc_trigger |-> trigger_irq == !IS_SECONDARY)
        else $error("interrupt mismatch");
    owner_reset_a: assert property ($fell(sys_rst) |-> ##1 high_side_output_oe && low_side_output_oe)
        else $error("pins not owned after reset");
    unmapped_zero_a: assert property (rd_none_s |=> reg_rdata == 16'h0)
        else $error("unmapped read not zero");
    idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 16'h0)
        else $error("read data without read");
endmodule : pin_ctl_checker

bind pwm_trigger_and_pin_control pin_ctl_checker #(.IS_SECONDARY(IS_SECONDARY)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .module_enable(module_enable), .trigger_event(trigger_event),
    .adc_trigger(adc_trigger), .trigger_irq(trigger_irq),
    .high_side_output_oe(high_side_output_oe), .low_side_output_oe(low_side_output_oe)
);

// file: verification/gate_adc_model.sv
`timescale 1ns/1ps
module gate_adc_model (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic adc_trigger, // conversion start pulse
    output int conv_cnt // conversions started
);
    always @(posedge clk) begin
        if (sys_rst) begin
            conv_cnt <= 0;
        end else if (adc_trigger) begin
            conv_cnt <= conv_cnt + 1;
        end
    end
endmodule : gate_adc_model

// file: verification/pwm_trigger_and_pin_control_tb_top.sv
`timescale 1ns/1ps
module pwm_trigger_and_pin_control_tb_top
    import pwm_trig_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic en = 1'b0;
    logic lock = 1'b0;
    logic [2:0] pl = 3'h0;
    pin_pair_t raw = 2'h2;
    pin_pair_t gout = 2'h1;
    pin_pair_t goe = 2'h1;
    logic [15:0] rdata, v;
    logic irq, irq2, trg, h, l, oeh, oel;
    int conv, irq_n, irq2_n, error_cnt, tests_run, c0;
    logic [3:0] dv [3] = '{4'h0, 4'h1, 4'hf};
    logic [15:0] pcfg [10] = '{16'hc000, 16'hc000, 16'hc400, 16'he000, 16'hd000, 16'hc002,
        16'h8000, 16'h4000, 16'hcc00, 16'hc800};
    logic [3:0] pexp [10] = '{4'hb, 4'h7, 4'hf, 4'h3, 4'hf, 4'h7, 4'hf, 4'h1, 4'hb, 4'hb};

    pwm_trigger_and_pin_control i_pwm_trigger_and_pin_control (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .module_enable(en), .pwm_cycle_start(pl[1]),
        .trigger_event(pl[0]), .pwm_raw(raw), .gpio_out(gout), .gpio_oe(goe),
        .config_write_lock(lock), .unlock_done(pl[2]), .adc_trigger(trg),
        .trigger_irq(irq), .high_side_output(h), .high_side_output_oe(oeh),
        .low_side_output(l), .low_side_output_oe(oel)
    );
    pwm_trigger_and_pin_control #(.IS_SECONDARY(1'b1)) i_pwm_trigger_and_pin_control_sec (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(), .module_enable(en), .pwm_cycle_start(pl[1]),
        .trigger_event(pl[0]), .pwm_raw(raw), .gpio_out(gout), .gpio_oe(goe),
        .config_write_lock(lock), .unlock_done(pl[2]), .adc_trigger(),
        .trigger_irq(irq2), .high_side_output(), .high_side_output_oe(),
        .low_side_output(), .low_side_output_oe()
    );
    gate_adc_model i_gate_adc_model (
        .clk(clk), .sys_rst(sys_rst), .adc_trigger(trg), .conv_cnt(conv)
    );

    always #4 clk = ~clk;
    always @(posedge clk) begin
        irq_n <= irq_n + int'(irq);
        irq2_n <= irq2_n + int'(irq2);
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask : rd_reg
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        pl <= m;
        @(posedge clk);
        pl <= 3'h0;
    endtask : pulse
    task automatic do_reset();
        sys_rst <= 1'b1;
        tick(16);
        sys_rst <= 1'b0;
    endtask : do_reset
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #50000;
        error_cnt++;
        close_out();
    end

    initial begin
        do_reset();
        rd_reg(TRGCTL_IDX);
        chk(v, 16'h0000);
        rd_reg(PINCTL_IDX);
        chk(v, 16'hc000);
        wr_reg(2'h3, 16'hffff);
        rd_reg(2'h3);
        chk(v, 16'h0000);
        wr_reg(TRGCTL_IDX, 16'hffff);
        rd_reg(TRGCTL_IDX);
        chk(v, 16'hf03f);
        $display("register test done");
        foreach (dv[k]) begin
            en <= 1'b0;
            wr_reg(TRGCTL_IDX, {dv[k], 12'h0});
            en <= 1'b1;
            tick(2);
            repeat (2) begin
                c0 = conv;
                repeat (dv[k]) pulse(3'h1);
                tick(3);
                chk(16'(conv - c0), 16'h0);
                pulse(3'h1);
                tick(3);
                chk(16'(conv - c0), 16'h1);
            end
        end
        chk(16'(conv), 16'h6);
        chk(16'(irq_n), 16'(conv));
        chk(16'(irq2_n), 16'h0);
        $display("divide test done");
        en <= 1'b0;
        wr_reg(TRGCTL_IDX, 16'h003f);
        en <= 1'b1;
        tick(2);
        c0 = conv;
        repeat (62) pulse(3'h2);
        pulse(3'h1);
        pulse(3'h2);
        pulse(3'h1);
        tick(3);
        chk(16'(conv - c0), 16'h1);
        $display("start delay test done");
        do_reset();
        for (int i = 0; i < 10; i++) begin
            raw <= (i == 1) ? 2'h1 : 2'h2;
            wr_reg(PINCTL_IDX, pcfg[i]);
            tick(3);
            chk({12'h0, h, l, oeh, oel}, {12'h0, pexp[i]});
        end
        pulse(3'h2);
        tick(2);
        chk({12'h0, h, l, oeh, oel}, 16'h0007);
        $display("pin test done");
        lock <= 1'b1;
        wr_reg(PINCTL_IDX, 16'hc002);
        rd_reg(PINCTL_IDX);
        chk(v, 16'hc800);
        rd_reg(STATUS_IDX);
        chk({15'h0, v[STAT_REJECT_BIT]}, 16'h0001);
        pulse(3'h4);
        wr_reg(PINCTL_IDX, 16'hc002);
        rd_reg(PINCTL_IDX);
        chk(v, 16'hc002);
        $display("lock test done");
        close_out();
    end
endmodule : pwm_trigger_and_pin_control_tb_top
